// >>> rtl/rxi_cfg.svh
// register map, field positions and reset values of the receive irq block
`ifndef RXI_CFG_SVH
`define RXI_CFG_SVH
`define RXI_ADDR_W 8
`define RXI_IDX_CTL 6'h06
`define RXI_IDX_MASK 6'h07
`define RXI_IDX_STAT 6'h08
`define RXI_IDX_DATA_A 6'h09
`define RXI_IDX_DATA_B 6'h0b
`define RXI_CTL_RST 3'h3
`define RXI_MASK_RST 8'h00
`define RXI_STAT_RST 8'h00
`define RXI_GAP_MSB 2
`define RXI_GAP_LSB 0
`define RXI_POS_FULL 0
`define RXI_POS_EOF 1
`define RXI_POS_FLOW 2
`define RXI_POS_OVF 2
`define RXI_POS_UDF 3
`define RXI_POS_VLD 3
`define RXI_CH_STRIDE 4
`define RXI_BYTE_BITS 4'h8
`define RXI_RESP_OKAY 2'h0
`define RXI_RESP_SLVERR 2'h2
`endif

// >>> rtl/rxi_pkg.sv
// types shared by the receive irq block
`include "rxi_cfg.svh"
package rxi_pkg;
  typedef struct packed {
    logic full;
    logic all_valid;
    logic eof;
    logic ovf;
    logic udf;
  } rxi_evt_t;

  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] nbits;
    logic seen;
    logic [3:0] gap_cnt;
    logic [7:0] hold;
    logic full;
    rxi_evt_t evt;
  } rxi_chan_st_t;

  typedef enum logic [1:0] {RD_IDLE, RD_ADDR, RD_RESP} rxi_rd_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [`RXI_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    rxi_rd_state_t rst;
    logic [`RXI_ADDR_W-1:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rxi_axi_st_t;

  typedef struct packed {
    logic [2:0] gap;
    logic [7:0] mask;
    logic [1:0] full;
    logic [1:0] eof;
    logic [1:0] ovf;
    logic [1:0] udf;
    logic [1:0] vld;
    logic irq;
  } rxi_st_t;
endpackage : rxi_pkg

// >>> rtl/rxi_chan.sv
// one receive channel: byte assembly, gap count and holding register
`timescale 1ns/100ps
`include "rxi_cfg.svh"
module rxi_chan (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic bit_tick, // one bit time elapsed
  input wire logic bit_valid, // bit of this bit time correlated
  input wire logic bit_data, // bit value
  input wire logic [2:0] gap_len, // frame gap length
  input wire logic host_rd, // host reads the data register
  output rxi_pkg::rxi_evt_t evt, // one-cycle events
  output logic [7:0] hold // holding register
);
  import rxi_pkg::*;
  rxi_chan_st_t s_reg, s_next;
  logic load;
  logic [7:0] ld_data;
  logic ld_all;
  logic [3:0] cnt_inc;

  always_comb begin
    s_next = s_reg;
    s_next.evt = '0;
    load = 1'b0;
    ld_data = s_reg.sh;
    ld_all = 1'b0;
    cnt_inc = s_reg.gap_cnt + 4'h1;
    if (host_rd) begin
      if (!s_reg.full) s_next.evt.udf = 1'b1;
      s_next.full = 1'b0;
    end
    if (bit_tick && bit_valid) begin
      ld_data = {s_reg.sh[6:0], bit_data};
      s_next.sh = ld_data;
      s_next.seen = 1'b1;
      s_next.gap_cnt = 4'h0;
      s_next.nbits = s_reg.nbits + 4'h1;
      if (s_next.nbits == `RXI_BYTE_BITS) begin
        load = 1'b1;
        ld_all = 1'b1;
        s_next.nbits = 4'h0;
      end
    end else if (bit_tick && s_reg.seen) begin
      s_next.gap_cnt = cnt_inc;
      if (cnt_inc > {1'b0, gap_len}) begin
        s_next.evt.eof = 1'b1;
        s_next.seen = 1'b0;
        s_next.gap_cnt = 4'h0;
        s_next.nbits = 4'h0;
        load = (s_reg.nbits != 4'h0);
      end
    end
    if (load) begin
      if (s_reg.full && !host_rd) s_next.evt.ovf = 1'b1;
      s_next.full = 1'b1;
      s_next.hold = ld_data;
      s_next.evt.full = 1'b1;
      s_next.evt.all_valid = ld_all;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign evt = s_reg.evt;
  assign hold = s_reg.hold;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_udf_on_empty: assert property (host_rd && !s_reg.full |=> evt.udf)
    else $error("underflow not flagged");
  a_ovf_on_load: assert property (
    s_reg.full && !host_rd && load |=> evt.ovf && evt.full)
    else $error("overflow not flagged");
  a_gap_zero: assert property (
    gap_len == 3'h0 && s_reg.seen && bit_tick && !bit_valid |=> evt.eof)
    else $error("eof missed at zero gap");
  a_eof_cause: assert property (evt.eof |-> $past(s_reg.seen))
    else $error("eof without prior valid bit");
endmodule : rxi_chan

// >>> rtl/rxi_axil.sv
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/100ps
`include "rxi_cfg.svh"
module rxi_axil (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic [`RXI_ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [`RXI_ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic wr_en, // register write strobe
  output logic [`RXI_ADDR_W-1:0] wr_addr, // register write address
  output logic [31:0] wr_data, // register write data
  output logic [3:0] wr_strb, // register write lanes
  input wire logic wr_err, // write address unmapped
  output logic rd_en, // register read strobe
  output logic [`RXI_ADDR_W-1:0] rd_addr, // register read address
  input wire logic [31:0] rd_data, // register read data
  input wire logic rd_err // read address unmapped
);
  import rxi_pkg::*;
  rxi_axi_st_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = awaddr;
    end
    if (wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready) s_next.bvalid = 1'b0;
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_err ? `RXI_RESP_SLVERR : `RXI_RESP_OKAY;
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;
    case (s_reg.rst)
      RD_IDLE: begin
        if (arvalid && s_reg.arready) begin
          s_next.araddr = araddr;
          s_next.rst = RD_ADDR;
        end
      end
      RD_ADDR: begin
        s_next.rdata = rd_data;
        s_next.rresp = rd_err ? `RXI_RESP_SLVERR : `RXI_RESP_OKAY;
        s_next.rvalid = 1'b1;
        s_next.rst = RD_RESP;
      end
      default: begin
        if (rready) begin
          s_next.rvalid = 1'b0;
          s_next.rst = RD_IDLE;
        end
      end
    endcase
    s_next.arready = (s_next.rst == RD_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign wr_en = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
  assign wr_addr = s_reg.awaddr;
  assign wr_data = s_reg.wdata;
  assign wr_strb = s_reg.wstrb;
  assign rd_en = (s_reg.rst == RD_ADDR);
  assign rd_addr = s_reg.araddr;
endmodule : rxi_axil

// >>> rtl/rxi_top.sv
// receive interrupt enable and status logic for two deserializer channels
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "rxi_cfg.svh"
module rxi_top (
  input wire logic aclk, // 125 MHz clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [`RXI_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`RXI_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [1:0] rx_bit_tick, // bit time strobe, per channel
  input wire logic [1:0] rx_bit_valid, // bit correlated, per channel
  input wire logic [1:0] rx_bit_data, // received bit, per channel
  output logic rx_irq // interrupt request, active high
);
  import rxi_pkg::*;

  // ***************************************************************
  // decode helpers
  // ***************************************************************
  function automatic logic hit(input logic [`RXI_ADDR_W-1:0] a,
                               input logic [5:0] idx);
    hit = (a[`RXI_ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  function automatic logic mapped(input logic [`RXI_ADDR_W-1:0] a);
    mapped = hit(a, `RXI_IDX_CTL) || hit(a, `RXI_IDX_MASK) ||
             hit(a, `RXI_IDX_STAT) || hit(a, `RXI_IDX_DATA_A) ||
             hit(a, `RXI_IDX_DATA_B);
  endfunction : mapped

  // status byte layout, channel B in the upper nibble
  function automatic logic [7:0] stat_of(input rxi_st_t st);
    logic [7:0] v;
    v = `RXI_STAT_RST;
    for (int c = 0; c < 2; c++) begin
      v[c*`RXI_CH_STRIDE + `RXI_POS_VLD] = st.vld[c];
      v[c*`RXI_CH_STRIDE + `RXI_POS_FLOW] = st.ovf[c] | st.udf[c];
      v[c*`RXI_CH_STRIDE + `RXI_POS_EOF] = st.eof[c];
      v[c*`RXI_CH_STRIDE + `RXI_POS_FULL] = st.full[c];
    end
    stat_of = v;
  endfunction : stat_of

  // pending events in the mask layout; valid bits take no part
  function automatic logic [7:0] pend_of(input rxi_st_t st);
    logic [7:0] v;
    v = 8'h00;
    for (int c = 0; c < 2; c++) begin
      v[c*`RXI_CH_STRIDE + `RXI_POS_UDF] = st.udf[c];
      v[c*`RXI_CH_STRIDE + `RXI_POS_OVF] = st.ovf[c];
      v[c*`RXI_CH_STRIDE + `RXI_POS_EOF] = st.eof[c];
      v[c*`RXI_CH_STRIDE + `RXI_POS_FULL] = st.full[c];
    end
    pend_of = v;
  endfunction : pend_of

  // ***************************************************************
  // bus front end
  // ***************************************************************
  logic wr_en;
  logic [`RXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [`RXI_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  rxi_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ***************************************************************
  // receive channels
  // ***************************************************************
  rxi_st_t s_reg, s_next;
  rxi_evt_t evt [2];
  logic [7:0] hold [2];
  logic [1:0] data_rd;
  logic stat_rd;
  logic stat_wr;
  logic ctl_wr;
  logic mask_wr;

  assign stat_rd = rd_en && hit(rd_addr, `RXI_IDX_STAT);
  assign data_rd[0] = rd_en && hit(rd_addr, `RXI_IDX_DATA_A);
  assign data_rd[1] = rd_en && hit(rd_addr, `RXI_IDX_DATA_B);
  assign stat_wr = wr_en && wr_strb[0] && hit(wr_addr, `RXI_IDX_STAT);
  assign ctl_wr = wr_en && wr_strb[0] && hit(wr_addr, `RXI_IDX_CTL);
  assign mask_wr = wr_en && wr_strb[0] && hit(wr_addr, `RXI_IDX_MASK);
  assign wr_err = !mapped(wr_addr);
  assign rd_err = !mapped(rd_addr);

  rxi_chan u_chan_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_tick(rx_bit_tick[0]),
    .bit_valid(rx_bit_valid[0]),
    .bit_data(rx_bit_data[0]),
    .gap_len(s_reg.gap),
    .host_rd(data_rd[0]),
    .evt(evt[0]),
    .hold(hold[0])
  );

  rxi_chan u_chan_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_tick(rx_bit_tick[1]),
    .bit_valid(rx_bit_valid[1]),
    .bit_data(rx_bit_data[1]),
    .gap_len(s_reg.gap),
    .host_rd(data_rd[1]),
    .evt(evt[1]),
    .hold(hold[1])
  );

  // ***************************************************************
  // register read mux
  // ***************************************************************
  always_comb begin
    if (hit(rd_addr, `RXI_IDX_CTL)) begin
      rd_data = {29'h0, s_reg.gap};
    end else if (hit(rd_addr, `RXI_IDX_MASK)) begin
      rd_data = {24'h0, s_reg.mask};
    end else if (hit(rd_addr, `RXI_IDX_STAT)) begin
      rd_data = {24'h0, stat_of(s_reg)};
    end else if (hit(rd_addr, `RXI_IDX_DATA_A)) begin
      rd_data = {24'h0, hold[0]};
    end else if (hit(rd_addr, `RXI_IDX_DATA_B)) begin
      rd_data = {24'h0, hold[1]};
    end else begin
      rd_data = 32'h0;
    end
  end

  // ***************************************************************
  // status flags, mask and interrupt
  // ***************************************************************
  logic [7:0] w1c;

  always_comb begin
    s_next = s_reg;
    w1c = stat_wr ? wr_data[7:0] : 8'h00;
    for (int c = 0; c < 2; c++) begin
      // new events win over a clear in the same cycle
      s_next.full[c] = evt[c].full | (s_reg.full[c] & !stat_rd &
        !w1c[c*`RXI_CH_STRIDE + `RXI_POS_FULL]);
      s_next.eof[c] = evt[c].eof | (s_reg.eof[c] & !stat_rd &
        !w1c[c*`RXI_CH_STRIDE + `RXI_POS_EOF]);
      s_next.ovf[c] = evt[c].ovf | (s_reg.ovf[c] & !stat_rd &
        !w1c[c*`RXI_CH_STRIDE + `RXI_POS_FLOW]);
      s_next.udf[c] = evt[c].udf | (s_reg.udf[c] & !stat_rd &
        !w1c[c*`RXI_CH_STRIDE + `RXI_POS_FLOW]);
      if (evt[c].full) s_next.vld[c] = evt[c].all_valid;
    end
    if (ctl_wr) s_next.gap = wr_data[`RXI_GAP_MSB:`RXI_GAP_LSB];
    if (mask_wr) s_next.mask = wr_data[7:0];
    s_next.irq = |(pend_of(s_next) & s_next.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.gap <= `RXI_CTL_RST;
      s_reg.mask <= `RXI_MASK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rx_irq = s_reg.irq;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_full_a_gate: assert property (
    evt[0].full && s_reg.mask[0] && !mask_wr |=> rx_irq)
    else $error("full A did not raise irq");
  a_eof_a_gate: assert property (
    evt[0].eof && s_reg.mask[1] && !mask_wr |=> rx_irq && s_reg.eof[0])
    else $error("eof A did not raise irq");
  a_ovf_a_gate: assert property (
    evt[0].ovf && s_reg.mask[2] && !mask_wr |=> rx_irq)
    else $error("overflow A did not raise irq");
  a_udf_a_gate: assert property (
    evt[0].udf && s_reg.mask[3] && !mask_wr |=> rx_irq)
    else $error("underflow A did not raise irq");
  a_full_b_gate: assert property (
    evt[1].full && s_reg.mask[4] && !mask_wr |=> rx_irq)
    else $error("full B did not raise irq");
  a_b_events_gate: assert property (
    ((evt[1].udf && s_reg.mask[7]) || (evt[1].ovf && s_reg.mask[6]) ||
     (evt[1].eof && s_reg.mask[5])) && !mask_wr |=> rx_irq)
    else $error("channel B event did not raise irq");
  a_mask_off_quiet: assert property (
    s_reg.mask == 8'h00 ##1 s_reg.mask == 8'h00 |-> !rx_irq)
    else $error("irq with all enables zero");
  a_eof_clear_read: assert property (
    stat_rd && !evt[0].eof |=> !s_reg.eof[0])
    else $error("eof A not cleared by status read");
  a_eof_held: assert property (
    s_reg.eof[0] && !stat_rd && !stat_wr |=> s_reg.eof[0])
    else $error("eof A dropped without read");
  a_flow_sets: assert property (
    evt[1].ovf || evt[1].udf |=> s_reg.ovf[1] || s_reg.udf[1])
    else $error("flow B not set");
  a_stat_layout: assert property (
    stat_rd |-> rd_data[7:0] == {s_reg.vld[1],
      s_reg.ovf[1] | s_reg.udf[1], s_reg.eof[1], s_reg.full[1],
      s_reg.vld[0], s_reg.ovf[0] | s_reg.udf[0], s_reg.eof[0],
      s_reg.full[0]})
    else $error("status layout wrong");
  a_reset_values: assert property (
    $rose(aresetn) |-> stat_of(s_reg) == `RXI_STAT_RST &&
      s_reg.gap == `RXI_CTL_RST)
    else $error("reset values wrong");
  a_valid_no_irq: assert property (
    s_reg.full == 2'h0 && s_reg.eof == 2'h0 && s_reg.ovf == 2'h0 &&
    s_reg.udf == 2'h0 |-> !rx_irq)
    else $error("irq with only valid bits set");
  a_valid_tracks: assert property (
    evt[0].full |=> s_reg.vld[0] == $past(evt[0].all_valid))
    else $error("valid A not updated on load");

  // ***************************************************************
  // status upkeep checks
  // ***************************************************************

  a_full_a_sets: assert property (
    evt[0].full |=> s_reg.full[0])
    else $error("full A not latched");

  a_full_b_sets: assert property (
    evt[1].full |=> s_reg.full[1])
    else $error("full B not latched");

  a_full_a_clear: assert property (
    stat_rd && !evt[0].full |=> !s_reg.full[0])
    else $error("full A not cleared by read");

  a_full_b_clear: assert property (
    stat_rd && !evt[1].full |=> !s_reg.full[1])
    else $error("full B not cleared by read");

  a_eof_b_clear: assert property (
    stat_rd && !evt[1].eof |=> !s_reg.eof[1])
    else $error("eof B not cleared by read");

  a_eof_b_held: assert property (
    s_reg.eof[1] && !stat_rd && !stat_wr |=> s_reg.eof[1])
    else $error("eof B dropped without read");

  a_flow_a_sets: assert property (
    evt[0].ovf || evt[0].udf |=> s_reg.ovf[0] || s_reg.udf[0])
    else $error("flow A not set");

  a_flow_a_clear: assert property (
    stat_rd && !evt[0].ovf && !evt[0].udf |=>
      !s_reg.ovf[0] && !s_reg.udf[0])
    else $error("flow A not cleared by read");

  a_flow_b_clear: assert property (
    stat_rd && !evt[1].ovf && !evt[1].udf |=>
      !s_reg.ovf[1] && !s_reg.udf[1])
    else $error("flow B not cleared by read");

  a_valid_b_tracks: assert property (
    evt[1].full |=> s_reg.vld[1] == $past(evt[1].all_valid))
    else $error("valid B not updated on load");

  a_valid_kept: assert property (
    stat_rd && !evt[0].full |=> s_reg.vld[0] == $past(s_reg.vld[0]))
    else $error("valid A changed by read");

  a_mask_all_on: assert property (
    mask_wr && wr_data[7:0] == 8'hff |=> s_reg.mask == 8'hff)
    else $error("mask write lost");

  a_irq_needs_en: assert property (
    rx_irq |-> (s_reg.mask & {s_reg.udf[1], s_reg.ovf[1], s_reg.eof[1],
      s_reg.full[1], s_reg.udf[0], s_reg.ovf[0], s_reg.eof[0],
      s_reg.full[0]}) != 8'h00)
    else $error("irq without enabled pending event");

  a_irq_after_rst: assert property (
    $rose(aresetn) |-> !rx_irq)
    else $error("irq high after reset");
endmodule : rxi_top

// >>> tb/rxi_host_model.sv
// axi4-lite host model issuing single register reads and writes
`timescale 1ns/100ps
module rxi_host_model (
  input logic aclk, // clock
  output logic [7:0] awaddr, // write address
  output logic awvalid, // aw valid
  input logic awready, // aw ready
  output logic [31:0] wdata, // write data
  output logic [3:0] wstrb, // lanes
  output logic wvalid, // w valid
  input logic wready, // w ready
  input logic [1:0] bresp, // b response
  input logic bvalid, // b valid
  output logic bready, // b ready
  output logic [7:0] araddr, // read address
  output logic arvalid, // ar valid
  input logic arready, // ar ready
  input logic [31:0] rdata, // read data
  input logic [1:0] rresp, // r response
  input logic rvalid, // r valid
  output logic rready // r ready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 8'h00;
    arvalid = 1'h0;
    rready = 1'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit to);
    int n;
    bit ad;
    bit dd;
    n = 0;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(ad && dd) && n < 64) begin
      @(posedge aclk);
      n++;
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'h0;
      end
      if (!dd && wready) begin
        dd = 1;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    while (!bvalid && n < 64) begin
      @(posedge aclk);
      n++;
    end
    r = bresp;
    bready <= 1'h0;
    to = (n >= 64);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit to);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    while (n < 64) begin
      @(posedge aclk);
      n++;
      if (arready) break;
    end
    arvalid <= 1'h0;
    rready <= 1'h1;
    while (!rvalid && n < 64) begin
      @(posedge aclk);
      n++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    to = (n >= 64);
  endtask : rd
endmodule : rxi_host_model

// >>> tb/tb_rxi_top.sv
// self-checking bench of the receive irq block
`timescale 1ns/100ps
`include "rxi_cfg.svh"
module tb_rxi_top;
  import rxi_pkg::*;
  typedef struct packed {
    logic c;
    logic [3:0] nv;
    logic [3:0] ni;
    logic [2:0] gap;
    logic [7:0] msk;
    logic [7:0] d;
    logic [7:0] st;
    logic irq;
  } rxi_row_t;
  localparam logic [7:0] A_CTL = {`RXI_IDX_CTL, 2'h0};
  localparam logic [7:0] A_MSK = {`RXI_IDX_MASK, 2'h0};
  localparam logic [7:0] A_STA = {`RXI_IDX_STAT, 2'h0};
  localparam logic [7:0] A_DA = {`RXI_IDX_DATA_A, 2'h0};
  localparam logic [7:0] A_DB = {`RXI_IDX_DATA_B, 2'h0};
  localparam logic [7:0] A_BAD = {6'h0a, 2'h0};
  rxi_row_t rows [7] = '{
    '{1'h0, 4'h8, 4'h1, 3'h0, 8'h01, 8'ha5, 8'h0b, 1'h1},
    '{1'h0, 4'h8, 4'h2, 3'h2, 8'hfc, 8'h3c, 8'h09, 1'h0},
    '{1'h0, 4'h3, 4'h3, 3'h2, 8'h02, 8'h05, 8'h03, 1'h1},
    '{1'h0, 4'h0, 4'h5, 3'h0, 8'hff, 8'h00, 8'h00, 1'h0},
    '{1'h1, 4'h8, 4'h1, 3'h0, 8'h10, 8'hc3, 8'hb0, 1'h1},
    '{1'h1, 4'h8, 4'h1, 3'h0, 8'h20, 8'h81, 8'hb0, 1'h1},
    '{1'h1, 4'h8, 4'h1, 3'h0, 8'hcf, 8'h7e, 8'hb0, 1'h0}
  };
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [1:0] tick = 2'h0;
  logic [1:0] vld = 2'h0;
  logic [1:0] dat = 2'h0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  int n_errors = 0;
  int total_checks = 0;

  always #4 aclk = ~aclk;

  rxi_top rxi_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_bit_tick(tick),
    .rx_bit_valid(vld), .rx_bit_data(dat), .rx_irq(irq));

  rxi_host_model rxi_host_model_inst (.aclk(aclk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic [1:0] r;
    bit to;
    rxi_host_model_inst.wr(a, d, r, to);
    if (to) begin
      n_errors++;
      wrap_up();
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm, input logic [1:0] er = 2'h0,
                    input logic [31:0] m = 32'hffffffff);
    logic [31:0] v;
    logic [1:0] r;
    bit to;
    rxi_host_model_inst.rd(a, v, r, to);
    if (to) begin
      n_errors++;
      wrap_up();
    end
    chk(nm, e & m, v & m);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd

  task automatic ckirq(input logic e);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : ckirq

  // msb first, valid bits then invalid bit times
  task automatic send(input logic c, input logic [3:0] nv,
                      input logic [3:0] ni, input logic [7:0] d);
    for (int i = 0; i < nv + ni; i++) begin
      @(posedge aclk);
      tick[c] <= 1'h1;
      vld[c] <= (i < nv);
      dat[c] <= (i < nv) ? d[nv - 1 - i] : 1'h0;
    end
    @(posedge aclk);
    tick <= 2'h0;
    vld <= 2'h0;
    repeat (4) @(posedge aclk);
  endtask : send

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    ckirq(1'h0);
    rd(A_STA, 32'h0, "status");
    rd(A_MSK, 32'h0, "mask");
    rd(A_CTL, 32'h3, "ctl");
    foreach (rows[i]) begin
      wr(A_CTL, {29'h0, rows[i].gap});
      wr(A_MSK, {24'h0, rows[i].msk});
      send(rows[i].c, rows[i].nv, rows[i].ni, rows[i].d);
      ckirq(rows[i].irq);
      rd(A_STA, {24'h0, rows[i].st}, "status");
      if (rows[i].nv != 4'h0)
        rd(rows[i].c ? A_DB : A_DA, {24'h0, rows[i].d}, "data", 2'h0,
           (32'h1 << rows[i].nv) - 32'h1);
      ckirq(1'h0);
    end
    wr(A_MSK, 32'h04);
    send(1'h0, 4'h8, 4'h0, 8'h11);
    send(1'h0, 4'h8, 4'h0, 8'h22);
    ckirq(1'h1);
    rd(A_STA, 32'h8d, "status");
    ckirq(1'h0);
    rd(A_DA, 32'h22, "data");
    rd(A_DA, 32'h0, "data", 2'h0, 32'h0);
    ckirq(1'h0);
    rd(A_STA, 32'h8c, "status");
    wr(A_MSK, 32'h08);
    rd(A_DA, 32'h0, "data", 2'h0, 32'h0);
    ckirq(1'h1);
    rd(A_STA, 32'h8c, "status");
    wr(A_MSK, 32'h80);
    rd(A_DB, 32'h0, "data", 2'h0, 32'h0);
    ckirq(1'h1);
    rd(A_STA, 32'hc8, "status");
    wr(A_BAD, 32'hff, `RXI_RESP_SLVERR);
    rd(A_BAD, 32'h0, "unmapped", `RXI_RESP_SLVERR);
    wr(A_MSK, 32'hff);
    send(1'h0, 4'h8, 4'h1, 8'h5a);
    ckirq(1'h1);
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    ckirq(1'h0);
    rd(A_STA, 32'h0, "status");
    rd(A_MSK, 32'h0, "mask");
    rd(A_CTL, 32'h3, "ctl");
    wr(A_MSK, 32'h01);
    send(1'h0, 4'h8, 4'h0, 8'h96);
    ckirq(1'h1);
    wr(A_STA, 32'h01);
    ckirq(1'h0);
    wr(A_DA, 32'hff);
    rd(A_STA, 32'h08, "status");
    rd(A_DA, 32'h96, "data");
    wrap_up();
  end
endmodule : tb_rxi_top
